//--- twmtx_pkg.sv
/*
 * Shared constants and types of the two-wire master transmitter handshake.
 * Assumes a single system clock at CLK_HZ and an SCL target rate of SCL_HZ.
 */
package twmtx_pkg;

	// Timing
	localparam int CLK_HZ      = 40_000_000;
	localparam int SCL_HZ      = 100_000;
	localparam int QUARTER_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

	// Widths
	localparam int BYTE_W  = 8;
	localparam int PRESC_W = 2;
	localparam int BITCNT_W = 4;

	// Bit index of the acknowledge slot within a byte transfer
	localparam logic [BITCNT_W-1:0] ACK_SLOT = 4'h8;

	// Status codes, prescaler bits zero
	localparam logic [BYTE_W-1:0] CODE_START     = 8'h08;
	localparam logic [BYTE_W-1:0] CODE_RSTART    = 8'h10;
	localparam logic [BYTE_W-1:0] CODE_ADDR_ACK  = 8'h18;
	localparam logic [BYTE_W-1:0] CODE_ADDR_NACK = 8'h20;
	localparam logic [BYTE_W-1:0] CODE_DATA_ACK  = 8'h28;
	localparam logic [BYTE_W-1:0] CODE_DATA_NACK = 8'h30;
	localparam logic [BYTE_W-1:0] CODE_NONE      = 8'hf8;
	localparam logic [BYTE_W-1:0] CODE_MASK      = 8'hf8;

	// Reset values
	localparam logic [BYTE_W-1:0] SHIFT_RESET = 8'h00;

	// Fields of one write to the serial_control_register
	typedef struct packed {
		logic enable;
		logic start;
		logic stop;
		logic pendClr;
	} twmtx_ctrl_t;

	typedef enum logic [3:0] {
		S_IDLE,
		S_START,
		S_HOLD,
		S_BITLO,
		S_BITHI,
		S_STOPLO,
		S_STOPHI,
		S_RSTART
	} twmtx_state_t;

	typedef struct packed {
		logic       cnt_unused;
		logic [7:0] cnt;
		logic       tick;
	} twmtx_tick_regs_t;

endpackage

//--- twmtx_tick.sv
/*
 * Quarter-bit enable divider for the two-wire master.
 * Assumes run is synchronous to clk; tick is a one-cycle pulse every DIV cycles.
 */
`timescale 1ns/10ps
module twmtx_tick #(
	parameter int DIV = 100
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Control
	input  wire logic run,
	// Enable out
	output logic      tick
);
	import twmtx_pkg::*;

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} twmtx_div_t;

	twmtx_div_t r;
	twmtx_div_t next_r;

	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (!run) begin
			next_r.cnt = '0;
		end else if (r.cnt == LAST) begin
			next_r.cnt = '0;
			next_r.tick = 1'b1;
		end else begin
			next_r.cnt = r.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick = r.tick;

endmodule

//--- twmtx_master.sv
/*
 * Byte-level handshake of a two-wire port acting as master transmitter:
 * control writes, pending flag, status codes, shift data register and the
 * START / byte / acknowledge / STOP sequencing on open-drain SCL and SDA.
 * Assumes external pull-ups; pin inputs are asynchronous and synchronised here.
 */
`timescale 1ns/10ps
module twmtx_master #(
	parameter int QUARTER = twmtx_pkg::QUARTER_CYC
) (
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      arst_n,
	// serial_control_register write
	input  wire logic                      ctrlWrite,
	input  wire twmtx_pkg::twmtx_ctrl_t    ctrlData,
	// shift_data_register write and read back
	input  wire logic                      dataWrite,
	input  wire logic [twmtx_pkg::BYTE_W-1:0] dataIn,
	output logic [twmtx_pkg::BYTE_W-1:0]   shiftData,
	// serial_status_register
	input  wire logic [twmtx_pkg::PRESC_W-1:0] prescaler,
	output logic [twmtx_pkg::BYTE_W-1:0]   status,
	output logic                           pending,
	output logic                           writeCollision,
	output logic                           busy,
	// Two-wire pins, open drain
	input  wire logic                      sclIn,
	output logic                           sclOut,
	output logic                           sclOe,
	input  wire logic                      sdaIn,
	output logic                           sdaOut,
	output logic                           sdaOe
);
	import twmtx_pkg::*;

	typedef struct packed {
		twmtx_state_t          state;
		logic                  q;
		logic [BITCNT_W-1:0]   bitCnt;
		logic                  pending;
		logic [BYTE_W-1:0]     status;
		logic [BYTE_W-1:0]     shiftData;
		logic                  collision;
		logic                  addrPhase;
		logic                  repeated;
		logic                  nack;
		logic                  busy;
		logic                  sclOe;
		logic                  sdaOe;
		logic                  sclMeta;
		logic                  sclSync;
		logic                  sdaMeta;
		logic                  sdaSync;
	} twmtx_regs_t;

	twmtx_regs_t r;
	twmtx_regs_t next_r;
	logic        tick;
	logic        clearReq;
	logic        busFree;

	// Status bits above the prescaler field
	function automatic logic [BYTE_W-1:0] post(input logic [BYTE_W-1:0] code,
	                                           input logic [PRESC_W-1:0] p);
		post = (code & CODE_MASK) | {{(BYTE_W-PRESC_W){1'b0}}, p};
	endfunction

	twmtx_tick #(
		.DIV (QUARTER)
	) u_tick (
		.clk    (sys_clk),
		.arst_n (arst_n),
		.run    (r.state != S_IDLE),
		.tick   (tick)
	);

	assign clearReq = ctrlWrite && ctrlData.pendClr && ctrlData.enable;
	assign busFree  = r.sclSync && r.sdaSync;

	always_comb begin
		next_r = r;
		// Pin synchronisers; the meta stages feed only the sync stages
		next_r.sclMeta = sclIn;
		next_r.sclSync = r.sclMeta;
		next_r.sdaMeta = sdaIn;
		next_r.sdaSync = r.sdaMeta;
		next_r.status[PRESC_W-1:0] = prescaler;

		// A data write lands only while pending; otherwise it is refused
		if (dataWrite) begin
			if (r.pending) begin
				next_r.shiftData = dataIn;
				next_r.collision = 1'b0;
			end else begin
				next_r.collision = 1'b1;
			end
		end

		unique case (r.state)
			S_IDLE: begin
				next_r.sclOe = 1'b0;
				next_r.sdaOe = 1'b0;
				if (clearReq && ctrlData.start) begin
					next_r.state = S_START;
					next_r.repeated = 1'b0;
					next_r.sdaOe = 1'b0;
				end
			end
			S_START: begin
				// Wait for a free bus, pull SDA with SCL high, then SCL low
				if (!r.sdaOe) begin
					if (tick && busFree) begin
						next_r.sdaOe = 1'b1;
						next_r.q = 1'b0;
					end
				end else if (tick) begin
					if (!r.q) begin
						next_r.q = 1'b1;
					end else begin
						next_r.sclOe = 1'b1;
						next_r.pending = 1'b1;
						next_r.status = post(r.repeated ? CODE_RSTART : CODE_START,
						                     prescaler);
						next_r.addrPhase = 1'b1;
						next_r.state = S_HOLD;
					end
				end
			end
			S_HOLD: begin
				next_r.sclOe = 1'b1;
				// Nothing moves until software clears the flag
				if (clearReq) begin
					next_r.pending = 1'b0;
					next_r.status = post(CODE_NONE, prescaler);
					next_r.q = 1'b0;
					if (ctrlData.start) begin
						next_r.state = S_RSTART;
						next_r.repeated = 1'b1;
					end else if (ctrlData.stop) begin
						next_r.state = S_STOPLO;
					end else begin
						next_r.state = S_BITLO;
						next_r.bitCnt = '0;
					end
				end
			end
			S_BITLO: begin
				next_r.sclOe = 1'b1;
				if (tick) begin
					if (!r.q) begin
						// Data bit MSB first; the acknowledge slot is released
						next_r.sdaOe = (r.bitCnt == ACK_SLOT) ? 1'b0 : !r.shiftData[BYTE_W-1];
						next_r.q = 1'b1;
					end else begin
						next_r.sclOe = 1'b0;
						next_r.q = 1'b0;
						next_r.state = S_BITHI;
					end
				end
			end
			S_BITHI: begin
				// Ticks count only while SCL is seen high, so a stretching
				// slave extends the high phase
				if (tick && r.sclSync) begin
					if (!r.q) begin
						next_r.q = 1'b1;
						if (r.bitCnt != ACK_SLOT) begin
							next_r.shiftData = {r.shiftData[BYTE_W-2:0], r.sdaSync};
						end else begin
							// Kept aside so the code is posted only with the flag
							next_r.nack = r.sdaSync;
						end
					end else begin
						next_r.sclOe = 1'b1;
						next_r.q = 1'b0;
						if (r.bitCnt == ACK_SLOT) begin
							next_r.pending = 1'b1;
							if (r.addrPhase) begin
								next_r.status = post(r.nack ? CODE_ADDR_NACK : CODE_ADDR_ACK,
								                     prescaler);
							end else begin
								next_r.status = post(r.nack ? CODE_DATA_NACK : CODE_DATA_ACK,
								                     prescaler);
							end
							next_r.addrPhase = 1'b0;
							next_r.state = S_HOLD;
						end else begin
							next_r.bitCnt = r.bitCnt + BITCNT_W'(1);
							next_r.state = S_BITLO;
						end
					end
				end
			end
			S_STOPLO: begin
				next_r.sclOe = 1'b1;
				if (tick) begin
					next_r.sdaOe = 1'b1;
					next_r.state = S_STOPHI;
				end
			end
			S_STOPHI: begin
				// SDA rises while SCL is high; no flag follows a STOP
				if (tick) begin
					if (r.sclOe) begin
						next_r.sclOe = 1'b0;
					end else if (r.sclSync) begin
						next_r.sdaOe = 1'b0;
						next_r.state = S_IDLE;
					end
				end
			end
			S_RSTART: begin
				next_r.sdaOe = 1'b0;
				if (tick) begin
					if (r.sclOe) begin
						next_r.sclOe = 1'b0;
					end else if (r.sclSync) begin
						next_r.state = S_START;
					end
				end
			end
		endcase

		// Disabling the port abandons any transfer and frees the lines
		if (ctrlWrite && !ctrlData.enable) begin
			next_r.state = S_IDLE;
			next_r.pending = 1'b0;
			next_r.status = post(CODE_NONE, prescaler);
			next_r.sclOe = 1'b0;
			next_r.sdaOe = 1'b0;
		end
		// Registered from the next state so busy keeps the state's timing
		next_r.busy = (next_r.state != S_IDLE);
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '{
				state:     S_IDLE,
				q:         1'b0,
				bitCnt:    '0,
				pending:   1'b0,
				status:    CODE_NONE,
				shiftData: SHIFT_RESET,
				collision: 1'b0,
				addrPhase: 1'b0,
				repeated:  1'b0,
				nack:      1'b0,
				busy:      1'b0,
				sclOe:     1'b0,
				sdaOe:     1'b0,
				sclMeta:   1'b1,
				sclSync:   1'b1,
				sdaMeta:   1'b1,
				sdaSync:   1'b1
			};
		end else begin
			r <= next_r;
		end
	end

	assign shiftData      = r.shiftData;
	assign status         = r.status;
	assign pending        = r.pending;
	assign writeCollision = r.collision;
	assign busy           = r.busy;
	assign sclOe          = r.sclOe;
	assign sdaOe          = r.sdaOe;
	// Open drain: the driven level is always low
	assign sclOut         = 1'b0;
	assign sdaOut         = 1'b0;

endmodule

//--- twmtx_master_asserts.sv
/* Port assertions of the two-wire master transmitter.
   Assumes one clock domain; bound to every twmtx_master. */
`timescale 1ns/10ps
module twmtx_master_asserts (
	// Clock and reset
	input wire logic                     sys_clk,
	input wire logic                     arst_n,
	// Software side
	input wire logic                     ctrlWrite,
	input wire twmtx_pkg::twmtx_ctrl_t   ctrlData,
	input wire logic                     dataWrite,
	input wire logic [7:0]               dataIn,
	input wire logic [7:0]               shiftData,
	input wire logic [7:0]               status,
	input wire logic                     pending,
	input wire logic                     writeCollision,
	input wire logic                     busy,
	// Pin enables
	input wire logic                     sclOe,
	input wire logic                     sdaOe
);
	import twmtx_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence sStartReq;
		ctrlWrite && ctrlData == 4'hd && !busy && !pending;
	endsequence
	sequence sStopReq;
		ctrlWrite && ctrlData == 4'hb && pending;
	endsequence
	AST_SCL_HELD: assert property (pending |-> sclOe)
		else $error("SCL released while pending");
	AST_CLR: assert property (ctrlWrite && ctrlData.enable && ctrlData.pendClr && pending
		|=> !pending) else $error("pending not cleared");
	AST_KEEP: assert property (ctrlWrite && ctrlData.enable && !ctrlData.pendClr && pending
		|=> pending) else $error("pending cleared by zero");
	AST_FREEZE: assert property (pending && !ctrlWrite
		|=> pending && $stable(status[7:3]) && $stable(sdaOe)) else $error("bus moved");
	AST_NONE: assert property (!pending == (status[7:3] == CODE_NONE[7:3]))
		else $error("status code and pending disagree");
	AST_START_BEGIN: assert property (sStartReq |=> busy && !pending)
		else $error("start not begun");
	AST_START_CODE: assert property (sStartReq
		|-> ##[1:400] (pending && status[7:3] == CODE_START[7:3])) else $error("no start code");
	AST_COLLIDE: assert property (dataWrite && !pending |=> writeCollision)
		else $error("collision not flagged");
	AST_LOAD: assert property (dataWrite && pending
		|=> shiftData == $past(dataIn) && !writeCollision) else $error("data not loaded");
	AST_STOP: assert property (sStopReq
		|=> !pending throughout (##[1:200] (!busy && !sclOe && !sdaOe))) else $error("bad stop");
endmodule
bind twmtx_master twmtx_master_asserts u_chk (.*);

//--- twmtx_slave.sv
/* Behavioural slave receiver on the two-wire bus.
   Assumes resolved wire levels; acknowledges each byte when ackEn is high. */
`timescale 1ns/10ps
module twmtx_slave (
	// Bus wires
	input  wire logic  scl,
	input  wire logic  sda,
	// Behaviour
	input  wire logic  ackEn,
	// Pull-down and captured traffic
	output logic       sdaOe,
	output logic [7:0] rxByte,
	output logic [3:0] rxCount
);
	logic [3:0] bitCnt = 4'h0;
	logic [7:0] shiftIn = 8'h00;
	logic       inFrame = 1'b0;
	initial begin
		sdaOe = 1'b0;
		rxByte = 8'h00;
		rxCount = 4'h0;
	end
	// START or repeated START restarts the byte
	always @(negedge sda) begin
		if (scl) begin
			bitCnt = 4'h0;
			inFrame = 1'b1;
		end
	end
	always @(posedge sda) begin
		if (scl)
			inFrame = 1'b0;
	end
	always @(posedge scl) begin
		if (inFrame && bitCnt < 4'h8)
			shiftIn = {shiftIn[6:0], sda};
		if (inFrame)
			bitCnt = bitCnt + 4'h1;
	end
	// Ack driven only in the ninth slot, released as it ends
	always @(negedge scl) begin
		if (inFrame && bitCnt == 4'h8)
			sdaOe = ackEn;
		if (inFrame && bitCnt == 4'h9) begin
			sdaOe = 1'b0;
			bitCnt = 4'h0;
			rxByte = shiftIn;
			rxCount = rxCount + 4'h1;
		end
	end
endmodule

//--- tb_twmtx_master.sv
/* Self-checking bench of the two-wire master transmitter.
   Assumes pull-ups on both lines and the slave model on the far side. */
`timescale 1ns/10ps
module tb_twmtx_master;
	import twmtx_pkg::*;
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        ctrlWrite = 1'b0;
	twmtx_ctrl_t ctrlData = '0;
	logic        dataWrite = 1'b0;
	logic [7:0]  dataIn = 8'h00;
	logic [1:0]  prescaler = 2'h0;
	logic        ackEn = 1'b1;
	logic [7:0]  shiftData, status, rxByte;
	logic [3:0]  rxCount;
	logic        pending, writeCollision, busy, sclOe, sdaOe, slvOe;
	logic        sclDrv, sdaDrv;
	wire         scl = !sclOe;
	wire         sda = !(sdaOe || slvOe);
	int          failures = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	always #12.5 sys_clk = ~sys_clk;
	twmtx_master #(.QUARTER(2)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
		.ctrlWrite(ctrlWrite), .ctrlData(ctrlData), .dataWrite(dataWrite), .dataIn(dataIn),
		.shiftData(shiftData), .prescaler(prescaler), .status(status), .pending(pending),
		.writeCollision(writeCollision), .busy(busy), .sclIn(scl), .sclOut(sclDrv),
		.sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaDrv), .sdaOe(sdaOe));
	twmtx_slave slv (.scl(scl), .sda(sda), .ackEn(ackEn), .sdaOe(slvOe), .rxByte(rxByte),
		.rxCount(rxCount));
	task automatic end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ctrl(input logic [3:0] v);
		@(negedge sys_clk);
		ctrlData = v;
		ctrlWrite = 1'b1;
		@(negedge sys_clk);
		ctrlWrite = 1'b0;
	endtask
	task automatic load(input logic [7:0] b);
		@(negedge sys_clk);
		dataIn = b;
		dataWrite = 1'b1;
		@(negedge sys_clk);
		dataWrite = 1'b0;
	endtask
	task automatic waitPend;
		int n;
		n = 0;
		while (pending !== 1'b1 && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		chk({7'h0, pending}, 8'h01);
	endtask
	task automatic t_reset;
		chk(status, CODE_NONE);
		chk({3'h0, pending, busy, writeCollision, sclOe, sdaOe}, 8'h00);
		chk({6'h0, sclDrv, sdaDrv}, 8'h00);
	endtask
	task automatic t_collide;
		load(8'h3c);
		chk({7'h0, writeCollision}, 8'h01);
		chk(shiftData, SHIFT_RESET);
	endtask
	task automatic t_start;
		chk({7'h0, busy}, 8'h00);
		ctrl(4'hd);
		chk({7'h0, busy}, 8'h01);
		waitPend;
		chk(status, CODE_START | 8'h02);
	endtask
	// Request without clearing: nothing may move
	task automatic t_hold;
		ctrl(4'hc);
		repeat (40) @(negedge sys_clk);
		chk({6'h0, pending, scl}, 8'h02);
		chk(status, CODE_START | 8'h02);
	endtask
	task automatic t_byte(input logic [7:0] b, input logic ack, input logic [7:0] code);
		logic [3:0] n0;
		n0 = rxCount;
		ackEn = ack;
		load(b);
		chk(shiftData, b);
		chk({7'h0, writeCollision}, 8'h00);
		ctrl(4'h9);
		waitPend;
		chk(status & CODE_MASK, code);
		chk(rxByte, b);
		chk({4'h0, rxCount}, {4'h0, n0 + 4'h1});
	endtask
	task automatic t_stop;
		int n;
		ctrl(4'hb);
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		repeat (20) @(negedge sys_clk);
		chk({6'h0, scl, sda}, 8'h03);
		chk({7'h0, pending}, 8'h00);
		chk(status, CODE_NONE | 8'h02);
	endtask
	// Start request while the flag is up gives a repeated START
	task automatic t_rstart;
		ctrl(4'hd);
		waitPend;
		chk(status, CODE_RSTART | 8'h02);
	endtask
	// Disabling the port mid-transfer frees both lines and drops the flag
	task automatic t_abort;
		ctrl(4'h0);
		chk({4'h0, pending, busy, sclOe, sdaOe}, 8'h00);
		chk(status, CODE_NONE | 8'h02);
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_sim;
		end
	end
	initial begin
		repeat (4) @(negedge sys_clk);
		arst_n = 1'b1;
		@(negedge sys_clk);
		t_reset;
		prescaler = 2'h2;
		t_collide;
		t_start;
		t_hold;
		t_byte(8'ha4, 1'b1, CODE_ADDR_ACK);
		t_byte(8'h5c, 1'b1, CODE_DATA_ACK);
		t_byte(8'h81, 1'b0, CODE_DATA_NACK);
		t_stop;
		t_start;
		t_byte(8'h52, 1'b0, CODE_ADDR_NACK);
		t_rstart;
		t_byte(8'ha6, 1'b1, CODE_ADDR_ACK);
		t_stop;
		t_start;
		t_abort;
		end_sim;
	end
endmodule
